// *** design/rsci_top.sv ***
`timescale 1ns/1ps
`include "rsci_defs.svh"
module rsci_top import rsci_pkg::*; #(
  parameter logic [7:0] FW_REV = 8'h10, // Arbitrary value
  parameter logic [7:0] MODEL_ID = 8'h5A, // Arbitrary value
  parameter logic [15:0] SERIAL_NO = 16'h0001, // Arbitrary value
  parameter int CLK_HZ = `RSCI_CLK_HZ,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic clock_in, // 250 MHz clock
  input wire logic rst_in, // Power-up reset
  input wire logic [7:0] switch_in, // Rear DIP switch
  output logic [4:0] gpib_addr_out, // Primary address
  input wire logic [7:0] gpib_rx_data_in, // Listened byte
  input wire logic gpib_rx_valid_in, // Listened byte strobe
  input wire logic gpib_talk_in, // Talk byte request
  output logic [7:0] gpib_tx_data_out, // Talked byte
  output logic gpib_tx_valid_out, // Talked byte strobe
  input wire logic dev_clear_in, // Device Clear
  input wire logic poll_in, // Serial poll done
  output logic [7:0] status_out, // Serial poll byte
  output logic srq_out, // Service request
  input wire logic uart_rx_in, // Serial receive
  output logic uart_tx_out, // Serial transmit
  output logic remote_out, // Front panel locked out
  output logic [11:0] volt_dac_out, // Voltage DAC
  output logic [11:0] curr_dac_out, // Current DAC
  output logic [31:0] trim_dac_out, // Four trim DACs
  output logic nvm_rd_out, // Trim read request
  output logic [1:0] nvm_addr_out, // Trim index
  input wire logic [7:0] nvm_data_in, // Trim data
  input wire logic nvm_ack_in, // Trim data valid
  output logic adc_start_out, // Start conversion
  output logic adc_chan_out, // Low volt, high current
  input wire logic [20:0] adc_data_in, // Raw conversion
  input wire logic adc_done_in, // Conversion done
  output logic trim_en_out, // Readback trim on
  output logic [9:0] volt_scale_out, // Scaling volts
  output logic [9:0] curr_scale_out // Scaling amps
);
  rsci_top_t st_ff;
  rsci_top_t nxt_st;
  rsci_strm_if #(.W(8)) fin ();
  rsci_strm_if #(.W(8)) fout ();
  logic rs_en;
  logic [7:0] urx_data;
  logic urx_valid;
  logic utx_ready;
  logic utx_valid;
  logic bvalid;
  logic [7:0] bdata;
  logic echo_req;
  logic msg_go;
  logic [7:0] msg_char;
  logic [13:0] acc;
  logic dig_ok;
  logic pct_ok;
  logic scl_ok;
  logic [11:0] pct_dac;

  function automatic logic is_dig(input logic [7:0] c);
    return c >= `RSCI_CH_0 && c <= `RSCI_CH_9;
  endfunction : is_dig

  function automatic logic [7:0] hexc(input logic [3:0] n);
    return (n < 4'hA) ? `RSCI_CH_0 + {4'h0, n} : `RSCI_CH_A7 + {4'h0, n};
  endfunction : hexc

  function automatic logic cmd2(input rsci_top_t s, input logic [7:0] a, input logic [7:0] b);
    return s.line[0] == a && s.line[1] == b;
  endfunction : cmd2

  rsci_fifo #(
    .W(8),
    .D(FIFO_DEPTH)
  ) u_fifo (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .wr(fin),
    .rd(fout)
  );

  rsci_uart #(
    .CLK_HZ(CLK_HZ)
  ) u_uart (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .rate_in(switch_in[7:5]),
    .rx_in(uart_rx_in),
    .rx_data_out(urx_data),
    .rx_valid_out(urx_valid),
    .tx_data_in(fout.data),
    .tx_valid_in(utx_valid),
    .tx_ready_out(utx_ready),
    .tx_out(uart_tx_out)
  );

  assign gpib_addr_out = st_ff.addr;
  assign gpib_tx_data_out = st_ff.gdata;
  assign gpib_tx_valid_out = st_ff.gvalid;
  assign status_out = {st_ff.pon, st_ff.srq, 1'b0, st_ff.ready, 4'h0};
  assign srq_out = st_ff.srq;
  assign remote_out = st_ff.remote;
  assign volt_dac_out = st_ff.vset;
  assign curr_dac_out = st_ff.iset;
  assign trim_dac_out = st_ff.trim;
  assign nvm_rd_out = st_ff.nvm_rd;
  assign nvm_addr_out = st_ff.tidx;
  assign adc_start_out = st_ff.adc_start;
  assign adc_chan_out = st_ff.adc_chan;
  assign trim_en_out = st_ff.trim_en;
  assign volt_scale_out = st_ff.vscale;
  assign curr_scale_out = st_ff.iscale;

  // Argument digits after the three-character prefix
  always_comb begin
    acc = 14'h0000;
    dig_ok = 1'b1;
    for (int i = `RSCI_ARG_POS; i < `RSCI_LINE_LEN; i++) begin
      if (i < int'(st_ff.len)) begin
        dig_ok = dig_ok && is_dig(st_ff.line[i]);
        acc = 14'(acc * 14'h000A) + {10'h000, st_ff.line[i][3:0]};
      end
    end
    pct_ok = dig_ok && st_ff.len > 4'h3 && st_ff.len < 4'h7 && acc <= `RSCI_PCT_MAX;
    scl_ok = dig_ok && st_ff.len == `RSCI_SCALE_LEN && acc <= `RSCI_SCALE_MAX;
    pct_dac = 12'((19'(acc) * `RSCI_DAC_FS) / 19'(`RSCI_PCT_MAX));
  end

  // Buffer fill and drain; echo beats messages to the buffer
  always_comb begin
    rs_en = switch_in[7:5] != 3'h0;
    bvalid = gpib_rx_valid_in || (urx_valid && rs_en);
    bdata = gpib_rx_valid_in ? gpib_rx_data_in : urx_data;
    echo_req = urx_valid && rs_en && st_ff.echo;
    if (st_ff.nib != 4'h0) begin
      msg_char = hexc(st_ff.msg[63:60]);
    end else if (st_ff.tail == 2'h2) begin
      msg_char = `RSCI_CR;
    end else begin
      msg_char = `RSCI_LF;
    end
    fin.valid = echo_req || st_ff.fsm == RSCI_MSG;
    fin.data = echo_req ? urx_data : msg_char;
    msg_go = st_ff.fsm == RSCI_MSG && !echo_req && fin.ready;
    fout.ready = gpib_talk_in || (rs_en && utx_ready);
    utx_valid = fout.valid && rs_en && !gpib_talk_in;
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_st.adc_start = 1'b0;
    nxt_st.addr = switch_in[4:0];
    nxt_st.gvalid = gpib_talk_in && fout.valid;
    if (gpib_talk_in && fout.valid) begin
      nxt_st.gdata = fout.data;
    end
    if (poll_in) begin
      nxt_st.srq = 1'b0;
    end
    unique case (st_ff.fsm)
      RSCI_LOAD: begin
        nxt_st.nvm_rd = 1'b1;
        if (nvm_ack_in) begin
          nxt_st.trim[st_ff.tidx] = nvm_data_in;
          nxt_st.tidx = st_ff.tidx + 2'h1;
          if (st_ff.tidx == 2'h3) begin
            nxt_st.nvm_rd = 1'b0;
            nxt_st.ready = 1'b1;
            nxt_st.fsm = RSCI_IDLE;
          end
        end
      end
      // Bytes outside idle are dropped; host waits for ready
      RSCI_IDLE: begin
        if (bvalid) begin
          if (bdata == `RSCI_CR) begin
            nxt_st.cr_seen = 1'b1;
          end else if (bdata == `RSCI_LF && st_ff.cr_seen) begin
            nxt_st.cr_seen = 1'b0;
            nxt_st.ready = 1'b0;
            nxt_st.has_msg = 1'b0;
            nxt_st.fsm = RSCI_EXEC;
          end else begin
            nxt_st.cr_seen = 1'b0;
            if (st_ff.len < 4'(`RSCI_LINE_LEN)) begin
              nxt_st.line[st_ff.len[2:0]] = bdata;
              nxt_st.len = st_ff.len + 4'h1;
            end
          end
        end
      end
      RSCI_EXEC: begin
        nxt_st.fsm = RSCI_END;
        if (cmd2(st_ff, `RSCI_CH_QM, `RSCI_CH_M)) begin
          nxt_st.msg = {FW_REV, MODEL_ID, SERIAL_NO, 2'h0, st_ff.vscale, 2'h0, st_ff.iscale, 8'h00};
          nxt_st.nib = `RSCI_ID_NIBS;
          nxt_st.tail = 2'h2;
          nxt_st.has_msg = 1'b1;
          nxt_st.fsm = RSCI_MSG;
        end else if (cmd2(st_ff, `RSCI_CH_M, `RSCI_CH_V) || cmd2(st_ff, `RSCI_CH_M, `RSCI_CH_C)) begin
          nxt_st.adc_start = 1'b1;
          nxt_st.adc_chan = st_ff.line[1] == `RSCI_CH_C;
          nxt_st.has_msg = 1'b1;
          nxt_st.fsm = RSCI_ADC;
        end else if (cmd2(st_ff, `RSCI_CH_S, `RSCI_CH_R)) begin
          nxt_st.remote = 1'b1;
        end else if (cmd2(st_ff, `RSCI_CH_S, `RSCI_CH_L)) begin
          nxt_st.remote = 1'b0;
        end else if (cmd2(st_ff, `RSCI_CH_S, `RSCI_CH_STAR) && scl_ok) begin
          if (st_ff.line[2] == `RSCI_CH_V) begin
            nxt_st.vscale = acc[9:0];
          end else if (st_ff.line[2] == `RSCI_CH_C) begin
            nxt_st.iscale = acc[9:0];
          end
        end else if (st_ff.line[0] == `RSCI_CH_S && (st_ff.line[2] == `RSCI_CH_0 || st_ff.line[2] == `RSCI_CH_1)) begin
          if (st_ff.line[1] == `RSCI_CH_B) begin
            nxt_st.echo = st_ff.line[2][0];
          end else if (st_ff.line[1] == `RSCI_CH_Q) begin
            nxt_st.srq_en = st_ff.line[2][0];
          end else if (st_ff.line[1] == `RSCI_CH_T) begin
            nxt_st.trim_en = st_ff.line[2][0];
          end
        end else if (st_ff.line[0] == `RSCI_CH_P && st_ff.line[2] == `RSCI_CH_PCT && pct_ok) begin
          if (st_ff.line[1] == `RSCI_CH_V) begin
            nxt_st.vset = pct_dac;
          end else if (st_ff.line[1] == `RSCI_CH_C) begin
            nxt_st.iset = pct_dac;
          end
        end
      end
      RSCI_ADC: begin
        if (adc_done_in) begin
          nxt_st.msg = {adc_data_in[20:`RSCI_RB_LSB], 48'h0};
          nxt_st.nib = `RSCI_RB_NIBS;
          nxt_st.tail = 2'h2;
          nxt_st.fsm = RSCI_MSG;
        end
      end
      RSCI_MSG: begin
        if (msg_go) begin
          if (st_ff.nib != 4'h0) begin
            nxt_st.msg = {st_ff.msg[59:0], 4'h0};
            nxt_st.nib = st_ff.nib - 4'h1;
          end else if (st_ff.tail == 2'h2) begin
            nxt_st.tail = 2'h1;
          end else begin
            nxt_st.fsm = RSCI_END;
          end
        end
      end
      RSCI_END: begin
        nxt_st.line = '0;
        nxt_st.len = 4'h0;
        nxt_st.ready = 1'b1;
        nxt_st.fsm = RSCI_IDLE;
        if (st_ff.has_msg && st_ff.srq_en) begin
          nxt_st.srq = 1'b1;
        end
      end
      default: begin
        nxt_st.fsm = RSCI_IDLE;
      end
    endcase
    if (dev_clear_in) begin
      nxt_st.vset = 12'h000;
      nxt_st.iset = 12'h000;
      nxt_st.pon = 1'b0;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      st_ff <= '0;
      st_ff.fsm <= RSCI_LOAD;
      st_ff.echo <= 1'b1;
      st_ff.trim_en <= 1'b1;
      st_ff.pon <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (rst_in);

  a_term_exec: assert property (
    st_ff.fsm == RSCI_EXEC |-> $past(bvalid) && $past(bdata) == `RSCI_LF && $past(st_ff.cr_seen))
    else $error("command ran without terminator");

  a_scale_keep: assert property (
    st_ff.fsm == RSCI_EXEC && cmd2(st_ff, `RSCI_CH_S, `RSCI_CH_STAR) && st_ff.line[2] == `RSCI_CH_V && scl_ok
    |=> {4'h0, volt_scale_out} == $past(acc))
    else $error("scaling value not stored");

  a_remote_on: assert property (
    st_ff.fsm == RSCI_EXEC && cmd2(st_ff, `RSCI_CH_S, `RSCI_CH_R) |=> remote_out)
    else $error("remote not entered");

  a_pct_prog: assert property (
    st_ff.fsm == RSCI_EXEC && cmd2(st_ff, `RSCI_CH_P, `RSCI_CH_V) && st_ff.line[2] == `RSCI_CH_PCT
    && pct_ok && !dev_clear_in |=> volt_dac_out == $past(pct_dac))
    else $error("percent voltage not programmed");

  a_meas_start: assert property (
    st_ff.fsm == RSCI_EXEC && cmd2(st_ff, `RSCI_CH_M, `RSCI_CH_V)
    |=> adc_start_out && !adc_chan_out && st_ff.fsm == RSCI_ADC ##1 !adc_start_out)
    else $error("voltage measure not started");

  a_trim_load: assert property (
    st_ff.fsm == RSCI_LOAD && nvm_ack_in && st_ff.tidx == 2'h3
    |=> status_out[4] && !nvm_rd_out && trim_dac_out[31:24] == $past(nvm_data_in))
    else $error("trim reload incomplete");

  a_trim_start: assert property (
    $past(rst_in) |-> trim_en_out && st_ff.fsm == RSCI_LOAD && !status_out[4])
    else $error("trim not on after reset");

  a_echo_push: assert property (
    urx_valid && rs_en && st_ff.echo |-> fin.valid && fin.data == urx_data)
    else $error("echo missing");

  a_ready_late: assert property (
    $rose(status_out[4]) |-> $past(st_ff.fsm) inside {RSCI_END, RSCI_LOAD})
    else $error("ready set before results");

  a_srq_bit: assert property (
    poll_in && !(st_ff.fsm == RSCI_END && st_ff.srq_en && st_ff.has_msg) |=> !status_out[6] && !srq_out)
    else $error("request bit not cleared by poll");

  a_pon_clear: assert property (
    dev_clear_in |=> !status_out[7] ##1 !status_out[7])
    else $error("power-on bit survived clear");

  a_srq_cause: assert property (
    $rose(srq_out) |-> $past(st_ff.srq_en) && $past(st_ff.has_msg) && $past(st_ff.fsm) == RSCI_END)
    else $error("request without cause");

  a_clear_zero: assert property (
    dev_clear_in |=> volt_dac_out == 12'h000 && curr_dac_out == 12'h000)
    else $error("clear did not zero converters");

  a_msg_tail: assert property (
    st_ff.fsm == RSCI_END && st_ff.has_msg |-> $past(fin.valid) && $past(fin.data) == `RSCI_LF)
    else $error("message not ended by line feed");

  a_unused_zero: assert property (
    status_out[3:0] == 4'h0 && !status_out[5])
    else $error("unused status bit set");

  c_remote_cmd: cover property (st_ff.fsm == RSCI_EXEC && cmd2(st_ff, `RSCI_CH_S, `RSCI_CH_R));
  c_meas_done: cover property (st_ff.fsm == RSCI_ADC && adc_done_in);
  c_srq_raise: cover property ($rose(srq_out));
  c_fifo_full: cover property (st_ff.fsm == RSCI_MSG && !fin.ready);
endmodule : rsci_top

// *** design/rsci_defs.svh ***
`ifndef RSCI_DEFS_SVH
`define RSCI_DEFS_SVH
// Contract
// - A command runs only after its CR (13) then LF (10) terminator.
// - The identify query puts revision, model, serial and rated values in the buffer.
// - Scaling commands take four digits 0000 to 1000 and store them.
// - Enter-remote locks out front panel; the converters drive the supply.
// - Percent programming sets the channel to that share of full scale.
// - Measure commands start a readback conversion and buffer the result.
// - Each of voltage and current has its own 12-bit converter.
// - Four 8-bit trim converters; values come from nonvolatile memory.
// - At power-up all trim levels reload before normal work.
// - Readback uses a 21-bit converter, reported as 16 bits.
// - Readback trim may be switched off but starts on after power-up.
// - Serial framing: one start, eight data, one stop, no handshake.
// - Three switches pick the rate: zero off, then 150 to 9600 doubling.
// - The other five switches give the bus primary address.
// - With echo on, each good serial character goes back; default on.
// - Ready bit 4 sets only when the results are already buffered.
// - Status bit 6 shows a service request was issued.
// - Bit 7 set at power-on, cleared by Device Clear.
// - With request enabled, raise SRQ when ready after a message command.
// - Device Clear zeroes both programming converters.
// - Buffer goes out serially after a command, readable on the bus; CR LF end.
`define RSCI_CLK_HZ 250000000
`define RSCI_BAUD_BASE 150
`define RSCI_CR 8'h0D
`define RSCI_LF 8'h0A
`define RSCI_LINE_LEN 8
`define RSCI_ARG_POS 3
`define RSCI_SCALE_LEN 4'h7
`define RSCI_SCALE_MAX 14'h03E8
`define RSCI_PCT_MAX 14'h0064
`define RSCI_DAC_FS 19'h00FFF
`define RSCI_RB_LSB 5
`define RSCI_ID_NIBS 4'hE
`define RSCI_RB_NIBS 4'h4
`define RSCI_CH_QM 8'h3F
`define RSCI_CH_M 8'h4D
`define RSCI_CH_V 8'h56
`define RSCI_CH_C 8'h43
`define RSCI_CH_S 8'h53
`define RSCI_CH_R 8'h52
`define RSCI_CH_L 8'h4C
`define RSCI_CH_B 8'h42
`define RSCI_CH_Q 8'h51
`define RSCI_CH_T 8'h54
`define RSCI_CH_P 8'h50
`define RSCI_CH_PCT 8'h25
`define RSCI_CH_STAR 8'h2A
`define RSCI_CH_0 8'h30
`define RSCI_CH_1 8'h31
`define RSCI_CH_9 8'h39
`define RSCI_CH_A7 8'h37
`endif

// *** design/rsci_pkg.sv ***
`include "rsci_defs.svh"
package rsci_pkg;
  typedef enum logic [2:0] {
    RSCI_LOAD = 3'h0,
    RSCI_IDLE = 3'h1,
    RSCI_EXEC = 3'h2,
    RSCI_ADC = 3'h3,
    RSCI_MSG = 3'h4,
    RSCI_END = 3'h5
  } rsci_state_t;

  typedef struct packed {
    rsci_state_t fsm;
    logic [1:0] tidx;
    logic nvm_rd;
    logic [3:0][7:0] trim;
    logic [`RSCI_LINE_LEN-1:0][7:0] line;
    logic [3:0] len;
    logic cr_seen;
    logic remote;
    logic echo;
    logic srq_en;
    logic trim_en;
    logic pon;
    logic srq;
    logic ready;
    logic has_msg;
    logic adc_start;
    logic adc_chan;
    logic [11:0] vset;
    logic [11:0] iset;
    logic [9:0] vscale;
    logic [9:0] iscale;
    logic [63:0] msg;
    logic [3:0] nib;
    logic [1:0] tail;
    logic [7:0] gdata;
    logic gvalid;
    logic [4:0] addr;
  } rsci_top_t;
endpackage : rsci_pkg

// *** design/rsci_strm_if.sv ***
`timescale 1ns/1ps
interface rsci_strm_if #(
  parameter int W = 8
);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src(output valid, output data, input ready);
  modport snk(input valid, input data, output ready);
endinterface : rsci_strm_if

// *** design/rsci_fifo.sv ***
`timescale 1ns/1ps
module rsci_fifo import rsci_pkg::*; #(
  parameter int W = 8,
  parameter int D = 16
) (
  input wire logic clock_in, // Clock
  input wire logic rst_in, // Sync reset
  rsci_strm_if.snk wr, // Fill side
  rsci_strm_if.src rd // Drain side
);
  localparam int AW = $clog2(D);
  if (D < 2 || (1 << AW) != D) begin : g_bad_depth
    $error("depth must be a power of two");
  end
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } rsci_fifo_t;
  rsci_fifo_t st_ff;
  rsci_fifo_t nxt_st;
  logic push;
  logic pop;

  assign wr.ready = st_ff.cnt != (AW+1)'(D);
  assign rd.valid = st_ff.cnt != '0;
  assign rd.data = st_ff.mem[st_ff.rp];

  always_comb begin
    push = wr.valid && wr.ready;
    pop = rd.valid && rd.ready;
    nxt_st = st_ff;
    if (push) begin
      nxt_st.mem[st_ff.wp] = wr.data;
      nxt_st.wp = st_ff.wp + 1'b1;
    end
    if (pop) begin
      nxt_st.rp = st_ff.rp + 1'b1;
    end
    nxt_st.cnt = st_ff.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule : rsci_fifo

// *** design/rsci_uart.sv ***
`timescale 1ns/1ps
`include "rsci_defs.svh"
module rsci_uart import rsci_pkg::*; #(
  parameter int CLK_HZ = `RSCI_CLK_HZ
) (
  input wire logic clock_in, // Clock
  input wire logic rst_in, // Sync reset
  input wire logic [2:0] rate_in, // Line rate code
  input wire logic rx_in, // Serial in
  output logic [7:0] rx_data_out, // Received byte
  output logic rx_valid_out, // Good byte pulse
  input wire logic [7:0] tx_data_in, // Byte to send
  input wire logic tx_valid_in, // Send request
  output logic tx_ready_out, // Can take a byte
  output logic tx_out // Serial out
);
  localparam int DW = $clog2(CLK_HZ / `RSCI_BAUD_BASE + 1);
  if (CLK_HZ < 64 * `RSCI_BAUD_BASE * 64) begin : g_bad_clk
    $error("clock too slow for fastest rate");
  end
  typedef struct packed {
    logic rbusy;
    logic [DW-1:0] rcnt;
    logic [3:0] rbit;
    logic [7:0] rsh;
    logic rvalid;
    logic tbusy;
    logic [DW-1:0] tcnt;
    logic [3:0] tbit;
    logic [9:0] tsh;
    logic txo;
  } rsci_uart_t;
  rsci_uart_t st_ff;
  rsci_uart_t nxt_st;
  logic [DW-1:0] div;
  logic en;

  function automatic logic [DW-1:0] div_of(input logic [2:0] r);
    int unsigned b;
    b = `RSCI_BAUD_BASE << (r - 3'h1);
    return DW'(CLK_HZ / b);
  endfunction : div_of

  assign rx_data_out = st_ff.rsh;
  assign rx_valid_out = st_ff.rvalid;
  assign tx_ready_out = en && !st_ff.tbusy;
  assign tx_out = st_ff.txo;

  always_comb begin
    en = rate_in != 3'h0;
    div = div_of(rate_in);
    nxt_st = st_ff;
    nxt_st.rvalid = 1'b0;
    if (!st_ff.rbusy) begin
      if (en && !rx_in) begin
        nxt_st.rbusy = 1'b1;
        nxt_st.rcnt = div >> 1;
        nxt_st.rbit = 4'h0;
      end
    end else if (st_ff.rcnt != '0) begin
      nxt_st.rcnt = st_ff.rcnt - 1'b1;
    end else begin
      nxt_st.rcnt = div - 1'b1;
      nxt_st.rbit = st_ff.rbit + 4'h1;
      if (st_ff.rbit == 4'h0 && rx_in) begin
        nxt_st.rbusy = 1'b0;
      end else if (st_ff.rbit == 4'h9) begin
        nxt_st.rbusy = 1'b0;
        nxt_st.rvalid = rx_in;
      end else if (st_ff.rbit != 4'h0) begin
        nxt_st.rsh = {rx_in, st_ff.rsh[7:1]};
      end
    end
    if (!st_ff.tbusy) begin
      if (tx_valid_in && en) begin
        nxt_st.tbusy = 1'b1;
        nxt_st.tsh = {1'b1, tx_data_in, 1'b0};
        nxt_st.tbit = 4'h0;
        nxt_st.tcnt = div - 1'b1;
        nxt_st.txo = 1'b0;
      end
    end else if (st_ff.tcnt != '0) begin
      nxt_st.tcnt = st_ff.tcnt - 1'b1;
    end else if (st_ff.tbit == 4'h9) begin
      nxt_st.tbusy = 1'b0;
    end else begin
      nxt_st.tsh = {1'b1, st_ff.tsh[9:1]};
      nxt_st.txo = st_ff.tsh[1];
      nxt_st.tbit = st_ff.tbit + 4'h1;
      nxt_st.tcnt = div - 1'b1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      st_ff <= '0;
      st_ff.txo <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule : rsci_uart

// *** verification/rsci_far_model.sv ***
`timescale 1ns/1ps
module rsci_far_model #(
  parameter logic [20:0] ADC_VAL = 21'h024680
) (
  input wire logic clock_in, // Clock
  input wire logic rst_in, // Sync reset
  input wire logic nvm_rd_in, // Trim read request
  input wire logic [1:0] nvm_addr_in, // Trim index
  output logic [7:0] nvm_data_out, // Trim data
  output logic nvm_ack_out, // Trim data valid
  input wire logic adc_start_in, // Start conversion
  output logic [20:0] adc_data_out, // Raw conversion
  output logic adc_done_out // Conversion done
);
  logic [2:0] cnt_ff;
  // Slow memory: one ack every other cycle, bus shows garbage between
  assign nvm_data_out = nvm_ack_out ? (8'hA0 | {6'h00, nvm_addr_in}) : ~(8'hA0 | {6'h00, nvm_addr_in});
  assign adc_done_out = (cnt_ff == 3'h1);
  assign adc_data_out = adc_done_out ? ADC_VAL : ~ADC_VAL;
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      nvm_ack_out <= 1'b0;
      cnt_ff <= 3'h0;
    end else begin
      nvm_ack_out <= nvm_rd_in & ~nvm_ack_out;
      cnt_ff <= adc_start_in ? 3'h5 : (cnt_ff != 3'h0 ? cnt_ff - 3'h1 : 3'h0);
    end
  end
endmodule : rsci_far_model

// *** verification/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] rx_data = 8'h00;
  logic rx_v = 1'b0;
  logic talk = 1'b0;
  logic clr = 1'b0;
  logic poll = 1'b0;
  logic ser_rx = 1'b1;
  logic ser_tx;
  logic [7:0] sw = 8'h06;
  logic [4:0] addr;
  logic [7:0] tx_data, status_out;
  logic tx_v, srq_out, remote_out, nvm_rd, nvm_ack, adc_start, adc_chan, adc_done, trim_en;
  logic [11:0] volt_dac, curr_dac;
  logic [31:0] trim_dac;
  logic [1:0] nvm_addr;
  logic [7:0] nvm_data;
  logic [20:0] adc_data;
  logic [9:0] vscale, iscale;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #2 clock_in = ~clock_in;
  // Slow serial clock: fastest rate is 64 cycles a bit
  rsci_top #(.CLK_HZ(614400)) uut (.clock_in(clock_in), .rst_in(rst_in), .switch_in(sw), .gpib_addr_out(addr),
    .gpib_rx_data_in(rx_data), .gpib_rx_valid_in(rx_v), .gpib_talk_in(talk), .gpib_tx_data_out(tx_data),
    .gpib_tx_valid_out(tx_v), .dev_clear_in(clr), .poll_in(poll), .status_out(status_out),
    .srq_out(srq_out), .uart_rx_in(ser_rx), .uart_tx_out(ser_tx), .remote_out(remote_out),
    .volt_dac_out(volt_dac), .curr_dac_out(curr_dac), .trim_dac_out(trim_dac), .nvm_rd_out(nvm_rd),
    .nvm_addr_out(nvm_addr), .nvm_data_in(nvm_data), .nvm_ack_in(nvm_ack), .adc_start_out(adc_start),
    .adc_chan_out(adc_chan), .adc_data_in(adc_data), .adc_done_in(adc_done), .trim_en_out(trim_en),
    .volt_scale_out(vscale), .curr_scale_out(iscale));
  rsci_far_model far (.clock_in(clock_in), .rst_in(rst_in), .nvm_rd_in(nvm_rd), .nvm_addr_in(nvm_addr),
    .nvm_data_out(nvm_data), .nvm_ack_out(nvm_ack), .adc_start_in(adc_start), .adc_data_out(adc_data),
    .adc_done_out(adc_done));
  task conclude;
    $display("Counts: %0d mismatches in %0d compares", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      conclude();
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic pulse(ref logic s);
    @(posedge clock_in);
    #1 s = 1'b1;
    @(posedge clock_in);
    #1 s = 1'b0;
  endtask : pulse
  task wait_rdy;
    int n;
    n = 0;
    repeat (2) @(posedge clock_in);
    #1;
    while (status_out[4] !== 1'b1 && n < 500) begin
      @(posedge clock_in);
      #1 n++;
    end
    chk(status_out[4], 1'b1);
  endtask : wait_rdy
  task put(input logic [7:0] b);
    @(posedge clock_in);
    #1 rx_data = b;
    rx_v = 1'b1;
  endtask : put
  task send(input string s);
    for (int i = 0; i < s.len(); i++) put(s[i]);
    put(8'h0D);
    put(8'h0A);
    @(posedge clock_in);
    #1 rx_v = 1'b0;
    wait_rdy();
  endtask : send
  task talk_byte(input logic [7:0] exp);
    pulse(talk);
    chk(tx_v, 1'b1);
    chk(tx_data, exp);
  endtask : talk_byte
  task t_boot;
    wait_rdy();
    chk(status_out, 8'h90);
    chk(trim_dac, 32'hA3A2A1A0);
    chk(trim_en, 1'b1);
    chk(addr, 5'h06);
    chk(remote_out, 1'b0);
    $display("test boot done");
  endtask : t_boot
  task t_program;
    send("SR");
    chk(remote_out, 1'b1);
    send("PV%50");
    chk(volt_dac, 12'h7FF);
    send("PC%100");
    chk(curr_dac, 12'hFFF);
    send("S*V0500");
    chk(vscale, 10'h1F4);
    send("S*V1001");
    chk(vscale, 10'h1F4);
    send("S*C1000");
    chk(iscale, 10'h3E8);
    send("ST0");
    chk(trim_en, 1'b0);
    $display("test program done");
  endtask : t_program
  task t_measure;
    send("SQ1");
    chk(srq_out, 1'b0);
    for (int k = 0; k < 2; k++) begin
      send(k == 0 ? "MV" : "MC");
      chk(adc_chan, k[0]);
      chk(srq_out, 1'b1);
      chk(status_out, 8'hD0);
      for (int j = 0; j < 4; j++) talk_byte(8'h31 + 8'(j));
      talk_byte(8'h0D);
      talk_byte(8'h0A);
      pulse(poll);
      @(posedge clock_in);
      #1 chk(status_out, 8'h90);
    end
    $display("test measure done");
  endtask : t_measure
  task automatic ser_put(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clock_in);
      #1 ser_rx = f[i];
      repeat (63) @(posedge clock_in);
    end
  endtask : ser_put
  task automatic ser_get(output logic [7:0] b);
    int n;
    n = 0;
    while (ser_tx !== 1'b0 && n < 2000) begin
      @(posedge clock_in);
      #1 n++;
    end
    repeat (32) @(posedge clock_in);
    for (int i = 0; i < 8; i++) begin
      repeat (64) @(posedge clock_in);
      #1 b[i] = ser_tx;
    end
    repeat (64) @(posedge clock_in);
    #1 chk(ser_tx, 1'b1);
  endtask : ser_get
  task t_serial;
    logic [7:0] got;
    sw = 8'hE6;
    fork
      ser_put(8'h0D);
      ser_get(got);
    join
    chk(got, 8'h0D);
    send("SB0");
    ser_put(8'h0D);
    #1 chk(ser_tx, 1'b1);
    $display("test serial done");
  endtask : t_serial
  task t_clear;
    pulse(clr);
    @(posedge clock_in);
    #1 chk(volt_dac, 12'h000);
    chk(curr_dac, 12'h000);
    chk(status_out[7], 1'b0);
    $display("test clear done");
  endtask : t_clear
  initial begin
    repeat (6) @(posedge clock_in);
    #1 rst_in = 1'b0;
    t_boot();
    t_program();
    t_measure();
    t_serial();
    t_clear();
    conclude();
  end
endmodule : tb_top
